// >>> hw/ima_pkg.sv
// constants and types for the serial command interpreter
package ima_pkg;

  localparam int BUF_DEPTH = 80;
  localparam int KW_LEN = 11;
  localparam int ID_DIGITS_MAX = 3;
  localparam int ID_MAX = 255;
  localparam int MSG_BYTES = 38;
  localparam int HOLD_W = 24;

  localparam logic [7:0] CH_ERASE = 8'h08;
  localparam logic [7:0] CH_TERM = 8'h0D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_PROMPT = 8'h3E;
  localparam logic [7:0] CH_DIGIT_LO = 8'h30;
  localparam logic [7:0] CH_DIGIT_HI = 8'h39;
  localparam logic [7:0] CH_NUL = 8'h00;

  // service mode command letters
  localparam logic [7:0] CMD_SSHOT = 8'h61;
  localparam logic [7:0] CMD_BIAS = 8'h62;
  localparam logic [7:0] CMD_DIAG = 8'h63;
  localparam logic [7:0] CMD_DGRAM = 8'h64;
  localparam logic [7:0] CMD_FILTER = 8'h66;
  localparam logic [7:0] CMD_GCOMP = 8'h67;
  localparam logic [7:0] CMD_SYSCFG = 8'h68;
  localparam logic [7:0] CMD_INFO = 8'h69;
  localparam logic [7:0] CMD_RATE = 8'h6D;
  localparam logic [7:0] CMD_TERMN = 8'h72;
  localparam logic [7:0] CMD_SAVE = 8'h73;
  localparam logic [7:0] CMD_TXPAR = 8'h74;
  localparam logic [7:0] CMD_UNIT = 8'h75;
  localparam logic [7:0] CMD_EXIT = 8'h78;
  localparam logic [7:0] CMD_FACTORY = 8'h7A;
  localparam logic [7:0] CMD_HELP = 8'h3F;

  // entry keyword as ascii bytes, first character in the top byte
  localparam logic [8*KW_LEN-1:0] KW_UTIL = 88'h5554494C4954594D4F4445;

  localparam logic [8*MSG_BYTES-1:0] MSG_TXT_PROMPT = {CH_TERM, CH_PROMPT, 288'h0};
  localparam logic [8*MSG_BYTES-1:0] MSG_TXT_E001 = {"E001 UNKNOWN COMMAND", CH_TERM, CH_TERM, CH_PROMPT, 120'h0};
  localparam logic [8*MSG_BYTES-1:0] MSG_TXT_E002 =
    {"E002 INCORRECT NUMBER OF PARAMETERS", CH_TERM, CH_TERM, CH_PROMPT};

  typedef logic [6:0] ima_cnt_t;
  typedef logic [7:0] ima_buf_t [BUF_DEPTH];

  typedef enum logic [1:0] {MSG_PROMPT = 2'h0, MSG_E001 = 2'h1, MSG_E002 = 2'h2} ima_msg_e;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_WAIT_DG = 3'h1,
    ST_HOLD = 3'h3,
    ST_UTIL = 3'h2,
    ST_SILENT = 3'h6,
    ST_SVC = 3'h7,
    ST_SVC_TX = 3'h5,
    ST_SVC_WAIT = 3'h4
  } ima_state_e;

  typedef struct packed {
    logic [7:0] code;
    ima_cnt_t len;
    ima_cnt_t commas;
  } ima_cmd_s;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } ima_id_s;

endpackage

// >>> hw/ima_cmd_interp.sv
// serial command interpreter: machine config mode entry and service mode line handling
//
// Overview of operation
// - bare entry command enters; addressed entry only if id matches; bad id ignored.
// - entry during a datagram waits until that datagram has finished.
// - addressed entry holds back the response for one datagram time.
// - after entry, utility responses are allowed without hold-back.
// - non-matching unit stops datagrams and ignores commands until exit.
// - on exit non-matching units resume datagrams without any reply.
// - service command letters are case-sensitive lower case.
// - sixteen single-character service commands are recognised.
// - ready prompt is carriage return followed by '>'.
// - every received service mode character is echoed.
// - the line is decoded and executed only on carriage return.
// - erase_char removes the last character since the last terminator.
// - input buffer holds 80 characters.
// - space separates command and first parameter, commas the rest.
// - errors are 'E', three digits, space, text, carriage return.
// - single-shot prints the latest background sample.
// - single-shot is unavailable with external trigger sample rate.
// - single-shot gives E001 for bad entry, E002 for extra characters.
`timescale 1ns/1ps

module ima_cmd_interp
  import ima_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial receive
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // serial transmit
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // datagram path
  input wire logic dg_busy,
  input wire logic [HOLD_W-1:0] dg_time_cyc,
  output logic dg_enable,
  // mode control
  input wire logic [7:0] unit_identifier,
  input wire logic ext_trig_rate,
  input wire logic svc_enter,
  input wire logic util_exit,
  output logic svc_mode,
  output logic util_mode,
  output logic util_resp_en,
  // command execution
  output logic cmd_exec,
  output ima_cmd_s cmd_info,
  input wire logic cmd_done,
  input wire logic [6:0] param_addr,
  output logic [7:0] param_data
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding functions

  function automatic logic kw_match(ima_buf_t b);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < KW_LEN; i++) begin
      ok = ok & (b[i] == KW_UTIL[8*(KW_LEN-1-i) +: 8]);
    end
    return ok;
  endfunction

  function automatic ima_id_s parse_id(ima_buf_t b, ima_cnt_t n);
    ima_id_s r;
    logic [9:0] val;
    val = 10'h0;
    r.valid = (n > ima_cnt_t'(KW_LEN + 1)) && (n <= ima_cnt_t'(KW_LEN + 1 + ID_DIGITS_MAX)) &&
              (b[KW_LEN] == CH_SPACE);
    for (int i = KW_LEN + 1; i < KW_LEN + 1 + ID_DIGITS_MAX; i++) begin
      if (ima_cnt_t'(i) < n) begin
        if (b[i] < CH_DIGIT_LO || b[i] > CH_DIGIT_HI) begin
          r.valid = 1'b0;
        end
        val = 10'(val * 10 + {6'h0, b[i][3:0]});
      end
    end
    if (val > 10'(ID_MAX)) begin
      r.valid = 1'b0;
    end
    r.value = val[7:0];
    return r;
  endfunction

  function automatic logic is_cmd(logic [7:0] c);
    return c inside {CMD_SSHOT, CMD_BIAS, CMD_DIAG, CMD_DGRAM, CMD_FILTER, CMD_GCOMP, CMD_SYSCFG, CMD_INFO,
                     CMD_RATE, CMD_TERMN, CMD_SAVE, CMD_TXPAR, CMD_UNIT, CMD_EXIT, CMD_FACTORY, CMD_HELP};
  endfunction

  function automatic logic [7:0] msg_char(ima_msg_e s, logic [5:0] i);
    logic [8*MSG_BYTES-1:0] v;
    v = MSG_TXT_PROMPT;
    if (s == MSG_E001) begin
      v = MSG_TXT_E001;
    end else if (s == MSG_E002) begin
      v = MSG_TXT_E002;
    end
    return v[8*(MSG_BYTES-1-int'(i)) +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and storage

  ima_state_e state_reg, state_next;
  ima_buf_t buf_mem;
  ima_cnt_t cnt_reg;
  ima_cnt_t comma_reg;
  logic ent_addr_reg;
  logic ent_match_reg;
  logic [HOLD_W-1:0] hold_reg;
  ima_msg_e msg_sel_reg;
  logic [5:0] msg_idx_reg;
  logic [7:0] tx_data_reg;
  logic tx_valid_reg;
  logic cmd_exec_reg;
  ima_cmd_s cmd_info_reg;
  logic [7:0] param_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // receive side decode

  wire in_svc = (state_reg == ST_SVC);
  wire line_mode = (state_reg == ST_NORMAL) | in_svc;
  wire tx_free = ~tx_valid_reg | tx_ready;
  wire rx_take = rx_valid & rx_ready;
  wire is_term = (rx_data == CH_TERM);
  wire is_erase = (rx_data == CH_ERASE);
  wire buf_full = (cnt_reg == ima_cnt_t'(BUF_DEPTH));
  wire line_end = rx_take & is_term & line_mode;
  wire do_erase = rx_take & is_erase & line_mode & (cnt_reg != 7'h00);
  wire do_store = rx_take & ~is_term & ~is_erase & line_mode & ~buf_full;
  wire [7:0] last_char = buf_mem[cnt_reg - 7'h01];

  // entry command recognition in normal mode
  wire kw_hit = kw_match(buf_mem);
  ima_id_s id_info;
  assign id_info = parse_id(buf_mem, cnt_reg);
  wire ent_bare = (cnt_reg == ima_cnt_t'(KW_LEN));
  wire ent_ok = kw_hit & (ent_bare | id_info.valid);
  wire ent_match = ent_bare | (id_info.value == unit_identifier);

  // service line decode
  wire [7:0] cmd_char = buf_mem[0];
  wire line_empty = (cnt_reg == 7'h00);
  wire cmd_known = is_cmd(cmd_char);
  wire sshot_bad = (cmd_char == CMD_SSHOT) & ext_trig_rate;
  wire sshot_extra = (cmd_char == CMD_SSHOT) & (cnt_reg != 7'h01);
  wire sep_bad = (cnt_reg > 7'h01) & (buf_mem[1] != CH_SPACE);
  wire svc_err1 = ~cmd_known | sshot_bad;
  wire svc_err2 = sshot_extra | sep_bad;
  wire svc_run = ~line_empty & ~svc_err1 & ~svc_err2;
  ima_msg_e svc_msg;
  assign svc_msg = line_empty ? MSG_PROMPT : svc_err1 ? MSG_E001 : MSG_E002;

  // outgoing message stream
  wire [7:0] msg_cur = (msg_idx_reg < 6'(MSG_BYTES)) ? msg_char(msg_sel_reg, msg_idx_reg) : CH_NUL;
  wire msg_load = (state_reg == ST_SVC_TX) & tx_free & (msg_cur != CH_NUL);
  wire msg_end = (state_reg == ST_SVC_TX) & tx_free & (msg_cur == CH_NUL);
  wire echo_load = rx_take & in_svc;
  wire msg_start = ((state_reg == ST_NORMAL) & svc_enter) | ((state_reg == ST_SVC_WAIT) & cmd_done) |
                   (line_end & in_svc);

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_NORMAL: begin
        if (svc_enter) begin
          state_next = ST_SVC_TX;
        end else if (line_end & ent_ok) begin
          state_next = ST_WAIT_DG;
        end
      end
      ST_WAIT_DG: begin
        if (~dg_busy) begin
          state_next = ~ent_match_reg ? ST_SILENT : ent_addr_reg ? ST_HOLD : ST_UTIL;
        end
      end
      ST_HOLD: begin
        if (hold_reg == '0) begin
          state_next = ST_UTIL;
        end
      end
      ST_UTIL, ST_SILENT: begin
        if (util_exit) begin
          state_next = ST_NORMAL;
        end
      end
      ST_SVC: begin
        if (line_end) begin
          state_next = ~svc_run ? ST_SVC_TX : (cmd_char == CMD_EXIT) ? ST_NORMAL : ST_SVC_WAIT;
        end
      end
      ST_SVC_TX: begin
        if (msg_end) begin
          state_next = ST_SVC;
        end
      end
      ST_SVC_WAIT: begin
        if (cmd_done) begin
          state_next = ST_SVC_TX;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_NORMAL;
      ent_addr_reg <= 1'b0;
      ent_match_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_NORMAL && line_end) begin
        ent_addr_reg <= ~ent_bare;
        ent_match_reg <= ent_match;
      end
      if (state_reg == ST_WAIT_DG) begin
        hold_reg <= dg_time_cyc;
      end else if (state_reg == ST_HOLD && hold_reg != '0) begin
        hold_reg <= hold_reg - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line buffer

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      comma_reg <= '0;
    end else if (line_end || (state_reg == ST_NORMAL && svc_enter)) begin
      cnt_reg <= '0;
      comma_reg <= '0;
    end else if (do_erase) begin
      cnt_reg <= cnt_reg - 7'h01;
      if (last_char == CH_COMMA) begin
        comma_reg <= comma_reg - 7'h01;
      end
    end else if (do_store) begin
      cnt_reg <= cnt_reg + 7'h01;
      if (rx_data == CH_COMMA) begin
        comma_reg <= comma_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_store) begin
      buf_mem[cnt_reg] <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit and command hand-off

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      msg_sel_reg <= MSG_PROMPT;
      msg_idx_reg <= '0;
    end else begin
      if (echo_load) begin
        tx_valid_reg <= 1'b1;
        tx_data_reg <= rx_data;
      end else if (msg_load) begin
        tx_valid_reg <= 1'b1;
        tx_data_reg <= msg_cur;
      end else if (tx_ready) begin
        tx_valid_reg <= 1'b0;
      end
      if (msg_start) begin
        msg_sel_reg <= in_svc ? svc_msg : MSG_PROMPT;
        msg_idx_reg <= '0;
      end else if (msg_load) begin
        msg_idx_reg <= msg_idx_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_exec_reg <= 1'b0;
      cmd_info_reg <= '0;
      param_data_reg <= 8'h00;
    end else begin
      cmd_exec_reg <= line_end & in_svc & svc_run;
      if (line_end && in_svc && svc_run) begin
        cmd_info_reg <= '{code: cmd_char, len: cnt_reg, commas: comma_reg};
      end
      param_data_reg <= (param_addr < ima_cnt_t'(BUF_DEPTH)) ? buf_mem[param_addr] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // service mode takes a character only when its echo can be sent at once
  assign rx_ready = in_svc ? tx_free : ((state_reg != ST_SVC_TX) && (state_reg != ST_SVC_WAIT));
  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign dg_enable = (state_reg == ST_NORMAL);
  assign svc_mode = in_svc | (state_reg == ST_SVC_TX) | (state_reg == ST_SVC_WAIT);
  assign util_mode = (state_reg == ST_HOLD) | (state_reg == ST_UTIL);
  assign util_resp_en = (state_reg == ST_UTIL);
  assign cmd_exec = cmd_exec_reg;
  assign cmd_info = cmd_info_reg;
  assign param_data = param_data_reg;

endmodule

// >>> tb/ima_props.sv
// checker: port-level properties of the command interpreter
`timescale 1ns/1ps

module ima_props
  import ima_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial streams
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  // modes and execution
  input wire logic [HOLD_W-1:0] dg_time_cyc,
  input wire logic dg_enable,
  input wire logic ext_trig_rate,
  input wire logic util_exit,
  input wire logic svc_mode,
  input wire logic util_mode,
  input wire logic util_resp_en,
  input wire logic cmd_exec,
  input wire ima_cmd_s cmd_info
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_echo_char: assert property (svc_mode && rx_valid && rx_ready |=> tx_valid && tx_data == $past(rx_data))
    else $error("received character not echoed");
  a_tx_stands: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit byte dropped before accepted");
  a_dg_quiet: assert property (svc_mode || util_mode |-> !dg_enable)
    else $error("datagrams enabled outside normal mode");
  a_resp_after: assert property (util_resp_en |-> util_mode && !svc_mode)
    else $error("utility response outside utility mode");
  a_exit_quiet: assert property (util_exit && util_resp_en |=> dg_enable && !tx_valid)
    else $error("exit did not resume datagrams quietly");
  a_exec_term: assert property (cmd_exec |-> $past(rx_valid && rx_ready && rx_data == CH_TERM))
    else $error("execution without line terminator");
  a_exec_pulse: assert property (cmd_exec |=> !cmd_exec)
    else $error("execute strobe longer than one cycle");
  a_no_trig_shot: assert property (cmd_exec && ext_trig_rate |-> cmd_info.code != CMD_SSHOT)
    else $error("single shot executed under external trigger");
  a_len_cap: assert property (cmd_exec |-> cmd_info.len <= 7'h50)
    else $error("line longer than buffer");
  a_hold_back: assert property ($rose(util_mode) && !util_resp_en && dg_time_cyc > 24'h000004
    |-> !util_resp_en [*4])
    else $error("addressed entry answered without hold-back");
  c_exec: cover property (cmd_exec && cmd_info.code == CMD_BIAS);
  c_util: cover property ($rose(util_resp_en));
  c_resume: cover property ($rose(dg_enable));
endmodule

// >>> tb/ima_host.sv
// host terminal model: accepts transmitted bytes, promptly or with stalls, and logs them
`timescale 1ns/1ps

module ima_host (
  // clock and pacing
  input wire logic core_clk,
  input wire logic slow,
  // device transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready = 1'b0
);
  logic [7:0] got [$];
  logic [1:0] ph = 2'h0;
  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= !slow || ph == 2'h3;
  end
endmodule

// >>> tb/tb_top.sv
// bench top: service line handling and config mode entry of the interpreter
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
  err_total++; $display("[ERR] %0t %h %h", $time, a, b); end end

module tb_top;
  import ima_pkg::*;
  logic core_clk = 0, rst = 1, rx_valid = 0, dg_busy = 0, ext_trig_rate = 0, svc_enter = 0, util_exit = 0;
  logic cmd_done = 0, slow = 0, rx_ready, tx_valid, tx_ready, dg_enable, svc_mode, util_mode, util_resp_en, cmd_exec;
  logic [7:0] rx_data = 0, unit_identifier = 8'h05, tx_data, param_data;
  logic [6:0] param_addr = 0;
  logic [HOLD_W-1:0] dg_time_cyc = 24'h00000A;
  ima_cmd_s cmd_info;
  int err_total = 0, checked = 0;
  string pr = "\r>", e1 = "E001 UNKNOWN COMMAND\r\r>", e2 = "E002 INCORRECT NUMBER OF PARAMETERS\r\r>";
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cmd_done <= cmd_exec;
  ima_cmd_interp u_dut (.core_clk, .rst, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .dg_busy,
    .dg_time_cyc, .dg_enable, .unit_identifier, .ext_trig_rate, .svc_enter, .util_exit, .svc_mode, .util_mode,
    .util_resp_en, .cmd_exec, .cmd_info, .cmd_done, .param_addr, .param_data);
  ima_host u_host (.core_clk, .slow, .tx_data, .tx_valid, .tx_ready);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // offer one character and hold it until the edge that takes it
  task automatic put(input logic [7:0] c);
    int n = 0;
    rx_data <= c;
    rx_valid <= 1'b1;
    @(negedge core_clk);
    while (!rx_ready && n < 500) begin
      n++;
      @(negedge core_clk);
    end
    if (n == 500) begin
      err_total++;
      finish_test();
    end
    @(posedge core_clk);
  endtask
  // send a line with terminator, then compare everything sent back
  task automatic run(input string s, input string e);
    int n = 0;
    u_host.got.delete();
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(CH_TERM);
    rx_valid <= 1'b0;
    while (u_host.got.size() < e.len() && n < 3000) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 3000) begin
      err_total++;
      finish_test();
    end
    repeat (20) @(posedge core_clk);
    `CHK(u_host.got.size(), e.len())
    for (int i = 0; i < e.len() && i < u_host.got.size(); i++) `CHK(u_host.got[i], e[i])
  endtask
  task automatic quit();
    util_exit <= 1'b1;
    @(posedge core_clk);
    util_exit <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK({dg_enable, util_mode, u_host.got.size() == 0}, 3'b101)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sc_util();
    int n = 0;
    string kw;
    kw = $sformatf("%s", KW_UTIL);
    run({kw, " 256"}, "");
    `CHK(dg_enable, 1'b1)
    dg_busy <= 1'b1;
    run({kw, " 5"}, "");
    `CHK({dg_enable, util_mode}, 2'b00)
    dg_busy <= 1'b0;
    while (!util_resp_en && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 100) begin
      err_total++;
      finish_test();
    end
    `CHK(n > 10, 1'b1)
    `CHK({util_mode, util_resp_en}, 2'b11)
    quit();
    run(kw, "");
    `CHK(util_resp_en, 1'b1)
    quit();
    unit_identifier <= 8'h07;
    run({kw, " 5"}, "");
    run(kw, "");
    `CHK({dg_enable, util_mode}, 2'b00)
    quit();
  endtask
  task automatic sc_svc();
    string c = "bcdfghimrstuz?";
    string s = "b ";
    u_host.got.delete();
    svc_enter <= 1'b1;
    @(posedge core_clk);
    svc_enter <= 1'b0;
    repeat (20) @(posedge core_clk);
    `CHK({u_host.got[0], u_host.got[1], svc_mode}, {CH_TERM, CH_PROMPT, 1'b1})
    run("a", {"a\r", pr});
    `CHK(cmd_info, {CMD_SSHOT, 7'h01, 7'h00})
    for (int i = 0; i < c.len(); i++) begin
      run(c.substr(i, i), {c.substr(i, i), "\r", pr});
      `CHK(cmd_info.code, c[i])
    end
    run("A", {"A\r", e1});
    run("e", {"e\r", e1});
    run("", {"\r", pr});
    run("a 1", {"a 1\r", e2});
    run("b,1", {"b,1\r", e2});
    ext_trig_rate <= 1'b1;
    run("a", {"a\r", e1});
    ext_trig_rate <= 1'b0;
    slow <= 1'b1;
    run("\010b 1,,\0102", {"\010b 1,,\0102\r", pr});
    `CHK(cmd_info, {CMD_BIAS, 7'h05, 7'h01})
    for (int i = 0; i < 81; i++) s = {s, "1"};
    run(s, {s, "\r", pr});
    `CHK(cmd_info.len, 7'h50)
    param_addr <= 7'h00;
    repeat (2) @(posedge core_clk);
    `CHK(param_data, CMD_BIAS)
    param_addr <= 7'h50;
    repeat (2) @(posedge core_clk);
    `CHK(param_data, CH_NUL)
    slow <= 1'b0;
    run("x", "x\r");
    `CHK({svc_mode, dg_enable}, 2'b01)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK({rx_ready, tx_valid, tx_data, cmd_exec, dg_enable, svc_mode, util_mode, util_resp_en}, {1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 3'h0})
    sc_util();
    sc_svc();
    finish_test();
  end
endmodule

bind ima_cmd_interp ima_props u_props (.core_clk, .rst, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid,
  .tx_ready, .dg_time_cyc, .dg_enable, .ext_trig_rate, .util_exit, .svc_mode, .util_mode, .util_resp_en,
  .cmd_exec, .cmd_info);
